// ==== design/prio_consts.svh ====
// offsets, field positions, reset values and counts of the priority register bank
`ifndef PRIO_CONSTS_SVH
`define PRIO_CONSTS_SVH

// ==========================================================================
// register word indices (byte address is four times the index)
`define PRIO_IDX_UART1RX_SPI1_TIMER3 4'h0
`define PRIO_IDX_DMA1_ADC_UART1TX 4'h1
`define PRIO_IDX_CHANGE_CMP_I2C1 4'h2
`define PRIO_IDX_EXTINT1 4'h3
`define PRIO_IDX_TIMER4_COMPARE_DMA2 4'h4
`define PRIO_IDX_UART2_EXTINT2_TIMER5 4'h5
`define PRIO_IDX_CAN_SPI2 4'h6
`define PRIO_IDX_CAPTURE_DMA3 4'h7
`define PRIO_REG_COUNT 8

// ==========================================================================
// field layout: four 3-bit slots, lsb at 0, 4, 8, 12; bit above each unused
`define PRIO_FIELD_W 3
`define PRIO_SLOT_STRIDE 4
`define PRIO_SLOTS 4
`define PRIO_SRC_COUNT 27

// ==========================================================================
// reset and special codes
`define PRIO_LEVEL_RESET 3'h4
`define PRIO_LEVEL_OFF 3'h0

// ==========================================================================
// implemented-slot masks, bit k set when slot k holds a field
`define PRIO_MASK_FULL 4'hF
`define PRIO_MASK_LOW3 4'h7
`define PRIO_MASK_LOW1 4'h1

`endif

// ==== design/prio_pkg.sv ====
// shared types of the priority register bank
package prio_pkg;

	// bus handshake states, one-hot
	typedef enum logic [1:0] {
		bus_idle = 2'b01,
		bus_ack = 2'b10
	} bus_state_e;

	// one priority level code
	typedef logic [2:0] level_t;

endpackage

// ==== design/level_register.sv ====
// one 16-bit priority register holding up to four 3-bit level fields
`timescale 1ns/1ps
`include "prio_consts.svh"

module level_register #(
	parameter logic [3:0] FIELD_MASK = `PRIO_MASK_FULL
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] byte_en,
	output logic [15:0] value
);

	logic [2:0] field_reg [4];

	// ======================================================================
	// field storage
	genvar k;
	generate
		for (k = 0; k < `PRIO_SLOTS; k++) begin : g_slot
			if (FIELD_MASK[k]) begin : g_impl
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n) begin
						field_reg[k] <= `PRIO_LEVEL_RESET;
					end else if (wr_en && byte_en[k/2]) begin
						field_reg[k] <= wr_data[k*`PRIO_SLOT_STRIDE +: `PRIO_FIELD_W];
					end
				end
			end else begin : g_none
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n) begin
						field_reg[k] <= `PRIO_LEVEL_OFF;
					end else begin
						field_reg[k] <= `PRIO_LEVEL_OFF;
					end
				end
			end
			// spare bit above field reads zero
			assign value[k*`PRIO_SLOT_STRIDE +: `PRIO_SLOT_STRIDE] = {1'b0, field_reg[k]};
		end
	endgenerate

endmodule

// ==== design/source_gate.sv ====
// turns level fields into per-source request-enable flags
`timescale 1ns/1ps
`include "prio_consts.svh"

module source_gate #(
	parameter int N = `PRIO_SRC_COUNT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3*N-1:0] levels,
	input wire logic [N-1:0] present,
	output logic [N-1:0] active
);

	// ======================================================================
	// one flag per source
	// code zero never requests
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				active[i] <= present[i] && (levels[3*i +: 3] != `PRIO_LEVEL_OFF);
			end
		end
	end

endmodule

// ==== design/interrupt_priority_regs.sv ====
// avalon-mm register bank of per-source interrupt priority levels
//
// Notes on behaviour
// - three-bit level, 7 highest, 1 lowest
// - level code zero disables the source
// - every field readable and writable by software
// - fields reset to level four
// - unimplemented bits ignore writes, read zero
// - uart1 rx, spi1, spi1 error, timer3
// - dma1, adc1, uart1 tx; top unused
// - change notify, comparator1, i2c1 master, slave
// - only external interrupt 1 at bottom
// - timer4, compare4, compare3, dma2
// - uart2 tx, uart2 rx, ext2, timer5
// - can event, can receive, spi2, spi2 error
// - no can module disables can sources
// - capture4, capture3, dma3; top unused
`timescale 1ns/1ps
`include "prio_consts.svh"

module interrupt_priority_regs #(
	parameter bit HAS_CAN = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output prio_pkg::level_t uart1_receive_level,
	output prio_pkg::level_t spi1_event_level,
	output prio_pkg::level_t spi1_error_level,
	output prio_pkg::level_t timer3_level,
	output prio_pkg::level_t dma_ch1_done_level,
	output prio_pkg::level_t adc1_done_level,
	output prio_pkg::level_t uart1_transmit_level,
	output prio_pkg::level_t change_notify_level,
	output prio_pkg::level_t comparator1_level,
	output prio_pkg::level_t i2c1_master_level,
	output prio_pkg::level_t i2c1_slave_level,
	output prio_pkg::level_t ext_irq1_level,
	output prio_pkg::level_t timer4_level,
	output prio_pkg::level_t compare4_level,
	output prio_pkg::level_t compare3_level,
	output prio_pkg::level_t dma_ch2_done_level,
	output prio_pkg::level_t uart2_transmit_level,
	output prio_pkg::level_t uart2_receive_level,
	output prio_pkg::level_t ext_irq2_level,
	output prio_pkg::level_t timer5_level,
	output prio_pkg::level_t can_event_level,
	output prio_pkg::level_t can_receive_level,
	output prio_pkg::level_t spi2_event_level,
	output prio_pkg::level_t spi2_error_level,
	output prio_pkg::level_t capture4_level,
	output prio_pkg::level_t capture3_level,
	output prio_pkg::level_t dma_ch3_done_level,
	output logic [`PRIO_SRC_COUNT-1:0] source_active
);

	// ======================================================================
	// helpers

	// true when the word index names a register of the bank
	function automatic logic addr_hit(input logic [3:0] addr);
		addr_hit = (addr < 4'(`PRIO_REG_COUNT));
	endfunction

	// which slots of a register hold a field
	function automatic logic [3:0] slot_mask(input int idx);
		case (idx)
			1: slot_mask = `PRIO_MASK_LOW3;
			3: slot_mask = `PRIO_MASK_LOW1;
			7: slot_mask = `PRIO_MASK_LOW3;
			default: slot_mask = `PRIO_MASK_FULL;
		endcase
	endfunction

	// ======================================================================
	// bus handshake state

	prio_pkg::bus_state_e state_reg;
	logic waitrequest_reg;
	logic [31:0] readdata_reg;
	logic commit_write;
	logic [15:0] reg_value [`PRIO_REG_COUNT];
	logic [15:0] read_value;

	// write lands on the edge where the master sees waitrequest low
	assign commit_write = avs_write && (state_reg == prio_pkg::bus_ack);

	// one wait cycle per access, then a single ready cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= prio_pkg::bus_idle;
		end else begin
			case (state_reg)
				prio_pkg::bus_idle: begin
					if (avs_read || avs_write) begin
						state_reg <= prio_pkg::bus_ack;
					end
				end
				prio_pkg::bus_ack: begin
					state_reg <= prio_pkg::bus_idle;
				end
				default: begin
					state_reg <= prio_pkg::bus_idle;
				end
			endcase
		end
	end

	// waitrequest high except in the ready cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= !((state_reg == prio_pkg::bus_idle) && (avs_read || avs_write));
		end
	end

	// ======================================================================
	// read path

	// unmapped addresses read as zero
	always_comb begin
		read_value = 16'h0000;
		if (addr_hit(avs_address)) begin
			read_value = reg_value[avs_address[2:0]];
		end
	end

	// read data captured for the ready cycle
	// upper half and spare bits zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_reg <= 32'h0000_0000;
		end else if (state_reg == prio_pkg::bus_idle && avs_read) begin
			readdata_reg <= {16'h0000, read_value};
		end
	end

	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;

	// ======================================================================
	// register bank

	genvar r;
	generate
		for (r = 0; r < `PRIO_REG_COUNT; r++) begin : g_reg
			level_register #(
				.FIELD_MASK(slot_mask(r))
			) u_reg (
				.clk(clk),
				.rst_n(rst_n),
				.wr_en(commit_write && addr_hit(avs_address) && (avs_address[2:0] == 3'(r))),
				.wr_data(avs_writedata[15:0]),
				.byte_en(avs_byteenable[1:0]),
				.value(reg_value[r])
			);
		end
	endgenerate

	// ======================================================================
	// field outputs, slots at bits 14-12, 10-8, 6-4, 2-0

	assign uart1_receive_level = reg_value[0][14:12];
	assign spi1_event_level = reg_value[0][10:8];
	assign spi1_error_level = reg_value[0][6:4];
	assign timer3_level = reg_value[0][2:0];
	assign dma_ch1_done_level = reg_value[1][10:8];
	assign adc1_done_level = reg_value[1][6:4];
	assign uart1_transmit_level = reg_value[1][2:0];
	assign change_notify_level = reg_value[2][14:12];
	assign comparator1_level = reg_value[2][10:8];
	assign i2c1_master_level = reg_value[2][6:4];
	assign i2c1_slave_level = reg_value[2][2:0];
	assign ext_irq1_level = reg_value[3][2:0];
	assign timer4_level = reg_value[4][14:12];
	assign compare4_level = reg_value[4][10:8];
	assign compare3_level = reg_value[4][6:4];
	assign dma_ch2_done_level = reg_value[4][2:0];
	assign uart2_transmit_level = reg_value[5][14:12];
	assign uart2_receive_level = reg_value[5][10:8];
	assign ext_irq2_level = reg_value[5][6:4];
	assign timer5_level = reg_value[5][2:0];
	assign can_event_level = reg_value[6][14:12];
	assign can_receive_level = reg_value[6][10:8];
	assign spi2_event_level = reg_value[6][6:4];
	assign spi2_error_level = reg_value[6][2:0];
	assign capture4_level = reg_value[7][10:8];
	assign capture3_level = reg_value[7][6:4];
	assign dma_ch3_done_level = reg_value[7][2:0];

	// ======================================================================
	// request-enable flags, index 0 is uart1 rx, 26 is dma3

	logic [3*`PRIO_SRC_COUNT-1:0] level_flat;
	logic [`PRIO_SRC_COUNT-1:0] present;

	assign level_flat = {
		dma_ch3_done_level, capture3_level, capture4_level,
		spi2_error_level, spi2_event_level, can_receive_level, can_event_level,
		timer5_level, ext_irq2_level, uart2_receive_level, uart2_transmit_level,
		dma_ch2_done_level, compare3_level, compare4_level, timer4_level,
		ext_irq1_level,
		i2c1_slave_level, i2c1_master_level, comparator1_level, change_notify_level,
		uart1_transmit_level, adc1_done_level, dma_ch1_done_level,
		timer3_level, spi1_error_level, spi1_event_level, uart1_receive_level
	};

	always_comb begin
		present = '1;
		// can event sits at index 20, can receive at 21; timer5 at 19 stays ungated
		present[20] = HAS_CAN;
		present[21] = HAS_CAN;
	end

	source_gate #(
		.N(`PRIO_SRC_COUNT)
	) u_gate (
		.clk(clk),
		.rst_n(rst_n),
		.levels(level_flat),
		.present(present),
		.active(source_active)
	);

endmodule

// ==== testbench/interrupt_priority_regs_assertions.sv ====
// checker of bus handshake, read data and level behaviour of the priority bank
`timescale 1ns/1ps
`include "prio_consts.svh"

module prio_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire prio_pkg::level_t ext_irq1_level,
	input wire prio_pkg::level_t timer3_level,
	input wire logic [`PRIO_SRC_COUNT-1:0] source_active
);
	// ==========================================================
	// handshake and read data
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	sequence ext1_commit;
		avs_write && !avs_waitrequest && avs_address == 4'h3 && avs_byteenable[0];
	endsequence
	one_wait_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	unused_zero_a: assert property (rd_done |-> (avs_readdata & 32'hFFFF8888) == 32'h0)
		else $error("unused read bits not zero");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[3]
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	ext1_only_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h3
		|-> avs_readdata[15:3] == 13'h0)
		else $error("upper bits of external level register not zero");
	// ==========================================================
	// level outputs and source gating
	ext1_update_a: assert property (ext1_commit
		|=> ext_irq1_level == $past(avs_writedata[2:0]))
		else $error("written level not seen next cycle");
	off_gates_a: assert property (ext_irq1_level == 3'h0 |=> !source_active[11])
		else $error("zero level still active");
	on_passes_a: assert property (timer3_level != 3'h0 |=> source_active[3])
		else $error("nonzero level not active");
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench of the priority register bank
`timescale 1ns/1ps

module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	prio_pkg::level_t lv [27];
	logic [26:0] source_active;
	logic [15:0] impl [8] = '{16'h7777, 16'h0777, 16'h7777, 16'h0007,
		16'h7777, 16'h7777, 16'h7777, 16'h0777};
	logic [15:0] exp [8];
	logic [31:0] q [$];
	logic [31:0] seed = 32'h823E;
	int err_total = 0;
	int checks_done = 0;

	// ==========================================================
	// clock and design
	always #4 clk = ~clk;

	interrupt_priority_regs #(.HAS_CAN(1'b0)) uut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.uart1_receive_level(lv[0]), .spi1_event_level(lv[1]), .spi1_error_level(lv[2]),
		.timer3_level(lv[3]), .dma_ch1_done_level(lv[4]), .adc1_done_level(lv[5]),
		.uart1_transmit_level(lv[6]), .change_notify_level(lv[7]), .comparator1_level(lv[8]),
		.i2c1_master_level(lv[9]), .i2c1_slave_level(lv[10]), .ext_irq1_level(lv[11]),
		.timer4_level(lv[12]), .compare4_level(lv[13]), .compare3_level(lv[14]),
		.dma_ch2_done_level(lv[15]), .uart2_transmit_level(lv[16]),
		.uart2_receive_level(lv[17]), .ext_irq2_level(lv[18]), .timer5_level(lv[19]),
		.can_event_level(lv[20]), .can_receive_level(lv[21]), .spi2_event_level(lv[22]),
		.spi2_error_level(lv[23]), .capture4_level(lv[24]), .capture3_level(lv[25]),
		.dma_ch3_done_level(lv[26]), .source_active(source_active));

	// ==========================================================
	// reporting
	task stop_test;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ==========================================================
	// bus master and model
	task bus(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
		int n;
		logic [15:0] m;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {~d, d};
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		if (!wr)
			q.push_back(!a[3] ? {16'h0, exp[a[2:0]]} : 32'h0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		// a bus that never answers counts as a mismatch; the run goes on to the report
		check(32'(avs_waitrequest), 32'h0);
		m = {{8{be[1]}}, {8{be[0]}}} & impl[a[2:0]];
		if (wr && !a[3])
			exp[a[2:0]] = (exp[a[2:0]] & ~m) | (d & m);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// compares each completed read with the oldest note
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0)
			check(avs_readdata, q.pop_front());
	end

	// walks fields in port order and compares levels and gating
	task check_all;
		int k;
		logic [2:0] f;
		k = 0;
		repeat (2) @(posedge clk);
		for (int r = 0; r < 8; r++) begin
			for (int s = 3; s >= 0; s--) begin
				if (impl[r][4*s]) begin
					f = exp[r][4*s +: 3];
					check(32'(lv[k]), 32'(f));
					check(32'(source_active[k]), 32'(f != 3'h0 && k != 20 && k != 21));
					k++;
				end
			end
		end
	endtask

	task do_reset;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int r = 0; r < 8; r++)
			exp[r] = impl[r] & 16'h4444;
	endtask

	task read_all;
		for (int a = 0; a < 16; a++)
			bus(1'b0, 4'(a), 16'h0, 4'hF);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		check_all();
		read_all();
		// every code in every field, unused bits set
		for (int c = 0; c < 8; c++) begin
			for (int a = 0; a < 8; a++)
				bus(1'b1, 4'(a), {4{1'b1, 3'(c)}}, 4'hF);
			check_all();
			read_all();
		end
		// random data, partial lanes, unmapped places
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			bus(1'b1, seed[3:0], seed[19:4], seed[23:20]);
			check_all();
		end
		read_all();
		do_reset();
		check_all();
		read_all();
		stop_test();
	end
endmodule

bind interrupt_priority_regs prio_checker u_chk (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.ext_irq1_level(ext_irq1_level), .timer3_level(timer3_level),
	.source_active(source_active));
